// [logic/rttc_map.svh]
`ifndef RTTC_MAP_SVH
`define RTTC_MAP_SVH
// Contract
// - Opcodes 0xFCCA and 0xFCCB carry transmit test.
// - Mode 0x00 sends basic packets.
// - Mode 0x01 sends continuous nine-bit PRBS.
// - Mode 0x02 sends continuous fifteen-bit PRBS.
// - Modes 0x03-0x05 send zeros, ones, alternating.
// - Modes 0x06-0x08 send runs of two, four, eight.
// - Modes above 0x08 are undefined.
// - Channel index 0x00 to 0x27 only.
// - Length byte sets payload bytes per packet; code sends one byte for length 0.
// - Payload 0x00 PRBS9, payload 0x03 PRBS15.
// - Payloads 0x01,02,04-07 repeat fixed bytes.
// - PHY 0x01 is 1M, 0x02 is 2M.
// - PHY 0x03 coded S8, 0x04 coded S2.
// - Power request -127..+20, actual power returned.
// - Maximum available power is returned.
// - First return byte is a status code.
// - Length and payload ignored in continuous modes.

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define RTTC_OPC_V2 16'hfcca
`define RTTC_OPC_V3 16'hfccb
`define RTTC_ADDR_OPCODE 4'h0
`define RTTC_ADDR_MODE 4'h1
`define RTTC_ADDR_CHAN 4'h2
`define RTTC_ADDR_LEN 4'h3
`define RTTC_ADDR_PAYLOAD 4'h4
`define RTTC_ADDR_PHY 4'h5
`define RTTC_ADDR_POWER 4'h6
`define RTTC_ADDR_GO 4'h7
`define RTTC_ADDR_STATUS 4'h8
`define RTTC_ADDR_PMAX 4'h9
`define RTTC_ADDR_PACT 4'ha
`define RTTC_ADDR_ACTIVE 4'hb
`define RTTC_MODE_MAX 8'h08
`define RTTC_CHAN_MAX 8'h27
`define RTTC_PAY_MAX 8'h07
`define RTTC_PHY_MIN 8'h01
`define RTTC_PHY_MAX 8'h04
`define RTTC_PWR_MIN 8'h81
`define RTTC_PWR_MAX 8'h14
`define RTTC_ST_OK 8'h00
`define RTTC_ST_UNKNOWN 8'h01
`define RTTC_ST_BADPARAM 8'h12
`define RTTC_PRBS9_SEED 9'h1ff
`define RTTC_PRBS15_SEED 15'h7fff
`endif

// [logic/rttc_pkg.sv]
package rttc_pkg;
	typedef enum logic [1:0] {
		RTTC_PHY_1M,
		RTTC_PHY_2M,
		RTTC_PHY_S8,
		RTTC_PHY_S2
	} rttc_phy_t;
	typedef struct packed {
		logic active;
		logic packet_tx_mode;
		logic [7:0] chan;
		rttc_phy_t phy;
		logic [7:0] power;
	} rttc_radio_t;
	typedef struct packed {
		logic bit_val;
		logic bit_valid;
		logic byte_last;
		logic pkt_last;
	} rttc_bits_t;
endpackage

// [logic/rttc_top.sv]
`timescale 1ns/1ps
`include "rttc_map.svh"
module rttc_top #(
	parameter logic [7:0] MAX_POWER_DBM = 8'h0a,
	parameter int BIT_DIV = 125
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	output rttc_pkg::rttc_radio_t o_radio,
	output rttc_pkg::rttc_bits_t o_bits
);
	import rttc_pkg::*;

	logic rst_s1_q, rst_n_q;
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// Command parameters
	// ----------------------------------------------------------------
	logic [15:0] opc_q;
	logic [7:0] mode_q, chan_q, len_q, pay_q, phy_q, pwr_q;
	logic [7:0] status_q, pact_q;
	logic active_q, pkt_q;
	logic [7:0] run_mode_q, run_pay_q, run_len_q;
	logic go;
	assign go = i_wr && i_addr == `RTTC_ADDR_GO;

	always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			opc_q <= 16'h0000;
			mode_q <= 8'h00;
			chan_q <= 8'h00;
			len_q <= 8'h00;
			pay_q <= 8'h00;
			phy_q <= `RTTC_PHY_MIN;
			pwr_q <= 8'h00;
		end else if (i_wr) begin
			unique case (i_addr)
				`RTTC_ADDR_OPCODE: opc_q <= i_wdata;
				`RTTC_ADDR_MODE: mode_q <= i_wdata[7:0];
				`RTTC_ADDR_CHAN: chan_q <= i_wdata[7:0];
				`RTTC_ADDR_LEN: len_q <= i_wdata[7:0];
				`RTTC_ADDR_PAYLOAD: pay_q <= i_wdata[7:0];
				`RTTC_ADDR_PHY: phy_q <= i_wdata[7:0];
				`RTTC_ADDR_POWER: pwr_q <= i_wdata[7:0];
				default: ;
			endcase
		end
	end

	// Power is clamped down to what the radio can give; there is no lower clamp, so values below the floor pass unchanged.
	function automatic logic [7:0] clamp_pwr(input logic [7:0] req);
		logic signed [7:0] r;
		r = signed'(req);
		if (r > signed'(MAX_POWER_DBM)) begin
			return MAX_POWER_DBM;
		end
		return req;
	endfunction

	logic opc_ok, par_ok, cmd_ok;
	assign opc_ok = opc_q == `RTTC_OPC_V2 || opc_q == `RTTC_OPC_V3;
	// Payload code is only checked in packet mode since it is ignored otherwise.
	assign par_ok = mode_q <= `RTTC_MODE_MAX
		&& chan_q <= `RTTC_CHAN_MAX
		&& (mode_q != 8'h00 || pay_q <= `RTTC_PAY_MAX)
		&& phy_q >= `RTTC_PHY_MIN && phy_q <= `RTTC_PHY_MAX
		&& (signed'(pwr_q) >= signed'(`RTTC_PWR_MIN))
		&& (signed'(pwr_q) <= signed'(`RTTC_PWR_MAX));
	assign cmd_ok = opc_ok && par_ok;

	rttc_phy_t phy_sel;
	always_comb begin
		unique case (phy_q[2:0])
			3'h2: phy_sel = RTTC_PHY_2M;
			3'h3: phy_sel = RTTC_PHY_S8;
			3'h4: phy_sel = RTTC_PHY_S2;
			default: phy_sel = RTTC_PHY_1M;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			status_q <= `RTTC_ST_OK;
			pact_q <= 8'h00;
			active_q <= 1'b0;
			pkt_q <= 1'b0;
			run_mode_q <= 8'h00;
			run_pay_q <= 8'h00;
			run_len_q <= 8'h00;
			o_radio <= '0;
		end else if (go) begin
			if (!opc_ok) begin
				status_q <= `RTTC_ST_UNKNOWN;
			end else if (!par_ok) begin
				status_q <= `RTTC_ST_BADPARAM;
			end else begin
				status_q <= `RTTC_ST_OK;
			end
			active_q <= cmd_ok;
			pkt_q <= mode_q == 8'h00;
			run_mode_q <= mode_q;
			run_pay_q <= pay_q;
			run_len_q <= len_q;
			pact_q <= cmd_ok ? clamp_pwr(pwr_q) : 8'h00;
			o_radio.active <= cmd_ok;
			o_radio.packet_tx_mode <= cmd_ok && mode_q == 8'h00;
			o_radio.chan <= chan_q;
			o_radio.phy <= phy_sel;
			o_radio.power <= clamp_pwr(pwr_q);
		end
	end

	// ----------------------------------------------------------------
	// Bit timing and pattern generation
	// ----------------------------------------------------------------
	logic [15:0] div_q;
	logic bit_en;
	// A start restarts the bit period, so the first bit of a new test comes at a known time
	// and no stale bit of the previous pattern slips out in the cycle of the start.
	assign bit_en = active_q && !go && div_q == 16'(BIT_DIV - 1);
	always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			div_q <= 16'h0000;
		end else if (!active_q || go || bit_en) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	logic [8:0] p9_q;
	logic [14:0] p15_q;
	logic [3:0] cnt_q;
	logic [2:0] bitpos_q;
	logic [7:0] bytecnt_q;
	always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			p9_q <= `RTTC_PRBS9_SEED;
			p15_q <= `RTTC_PRBS15_SEED;
			cnt_q <= 4'h0;
		end else if (go) begin
			p9_q <= `RTTC_PRBS9_SEED;
			p15_q <= `RTTC_PRBS15_SEED;
			cnt_q <= 4'h0;
		end else if (bit_en) begin
			p9_q <= {p9_q[7:0], p9_q[8] ^ p9_q[4]};
			p15_q <= {p15_q[13:0], p15_q[14] ^ p15_q[13]};
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// The last bit of the last payload byte closes a packet; a zero length acts as one byte.
	logic pkt_end;
	assign pkt_end = bitpos_q == 3'h7 && bytecnt_q + 8'h01 >= run_len_q;

	// Packet byte framing; runs only in packet mode.
	always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			bitpos_q <= 3'h0;
			bytecnt_q <= 8'h00;
		end else if (go) begin
			bitpos_q <= 3'h0;
			bytecnt_q <= 8'h00;
		end else if (bit_en && pkt_q) begin
			bitpos_q <= bitpos_q + 3'h1;
			if (bitpos_q == 3'h7) begin
				bytecnt_q <= pkt_end ? 8'h00 : bytecnt_q + 8'h01;
			end
		end
	end

	function automatic logic fixed_byte(input logic [7:0] code, input logic [2:0] pos);
		logic [7:0] b;
		unique case (code)
			8'h01: b = 8'hf0;
			8'h02: b = 8'haa;
			8'h04: b = 8'hff;
			8'h06: b = 8'h0f;
			8'h07: b = 8'h55;
			default: b = 8'h00;
		endcase
		return b[3'h7 - pos];
	endfunction

	logic cur_bit;
	always_comb begin
		cur_bit = 1'b0;
		if (pkt_q) begin
			unique case (run_pay_q)
				8'h00: cur_bit = p9_q[8];
				8'h03: cur_bit = p15_q[14];
				default: cur_bit = fixed_byte(run_pay_q, bitpos_q);
			endcase
		end else begin
			unique case (run_mode_q)
				8'h01: cur_bit = p9_q[8];
				8'h02: cur_bit = p15_q[14];
				8'h04: cur_bit = 1'b1;
				8'h05: cur_bit = cnt_q[0];
				8'h06: cur_bit = cnt_q[1];
				8'h07: cur_bit = cnt_q[2];
				8'h08: cur_bit = cnt_q[3];
				default: cur_bit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_bits <= '0;
		end else begin
			o_bits.bit_valid <= bit_en;
			o_bits.bit_val <= bit_en ? cur_bit : 1'b0;
			o_bits.byte_last <= bit_en && pkt_q && bitpos_q == 3'h7;
			o_bits.pkt_last <= bit_en && pkt_q && pkt_end;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_rdata <= 16'h0000;
		end else if (i_rd) begin
			unique case (i_addr)
				`RTTC_ADDR_OPCODE: o_rdata <= opc_q;
				`RTTC_ADDR_MODE: o_rdata <= {8'h00, mode_q};
				`RTTC_ADDR_CHAN: o_rdata <= {8'h00, chan_q};
				`RTTC_ADDR_LEN: o_rdata <= {8'h00, len_q};
				`RTTC_ADDR_PAYLOAD: o_rdata <= {8'h00, pay_q};
				`RTTC_ADDR_PHY: o_rdata <= {8'h00, phy_q};
				`RTTC_ADDR_POWER: o_rdata <= {8'h00, pwr_q};
				`RTTC_ADDR_STATUS: o_rdata <= {8'h00, status_q};
				`RTTC_ADDR_PMAX: o_rdata <= {8'h00, MAX_POWER_DBM};
				`RTTC_ADDR_PACT: o_rdata <= {8'h00, pact_q};
				`RTTC_ADDR_ACTIVE: o_rdata <= {15'h0000, active_q};
				default: o_rdata <= 16'h0000;
			endcase
		end else begin
			o_rdata <= 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	bad_opc_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		go && !opc_ok |=> !active_q && status_q == `RTTC_ST_UNKNOWN)
		else $error("unknown opcode started a test");
	bad_mode_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		go && mode_q > `RTTC_MODE_MAX |=> !active_q && status_q != `RTTC_ST_OK)
		else $error("reserved mode accepted");
	bad_chan_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		go && chan_q > `RTTC_CHAN_MAX |=> !o_radio.active)
		else $error("out of range channel accepted");
	bad_phy_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		go && (phy_q == 8'h00 || phy_q > `RTTC_PHY_MAX) |=> status_q == `RTTC_ST_BADPARAM
		|| status_q == `RTTC_ST_UNKNOWN)
		else $error("reserved phy accepted");
	pkt_mode_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		go && cmd_ok && mode_q == 8'h00 |=> o_radio.packet_tx_mode && o_radio.active)
		else $error("packet mode not entered");
	ones_bits_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		bit_en && !pkt_q && run_mode_q == 8'h04 |=> o_bits.bit_val)
		else $error("all ones pattern broken");
	pact_clamp_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		go && cmd_ok |=> signed'(pact_q) <= signed'(MAX_POWER_DBM))
		else $error("actual power above maximum");
	no_tx_idle_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		!active_q |=> !o_bits.bit_valid)
		else $error("bits sent while idle");
	phy_map_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		go && cmd_ok && phy_q == 8'h03 |=> o_radio.phy == RTTC_PHY_S8)
		else $error("coded S8 phy not selected");
	good_opc_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		go && opc_q == `RTTC_OPC_V3 && par_ok |=> active_q && status_q == `RTTC_ST_OK)
		else $error("third version command not started");
	prbs9_bits_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		bit_en && !pkt_q && run_mode_q == 8'h01 |=> o_bits.bit_val == $past(p9_q[8]))
		else $error("nine bit sequence broken");
	prbs15_bits_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		bit_en && !pkt_q && run_mode_q == 8'h02 |=> o_bits.bit_val == $past(p15_q[14]))
		else $error("fifteen bit sequence broken");
	zeros_bits_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		bit_en && !pkt_q && run_mode_q == 8'h03 |=> !o_bits.bit_val)
		else $error("all zeros pattern broken");
	alt_bits_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		bit_en && !pkt_q && run_mode_q == 8'h05 |=> o_bits.bit_val == $past(cnt_q[0]))
		else $error("alternating pattern broken");
	runs_bits_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		bit_en && !pkt_q && run_mode_q == 8'h06 |=> o_bits.bit_val == $past(cnt_q[1]))
		else $error("runs of two pattern broken");
	pkt_last_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		o_bits.pkt_last |-> o_bits.byte_last)
		else $error("packet ended inside a byte");
	pay_prbs9_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		bit_en && pkt_q && run_pay_q == 8'h00 |=> o_bits.bit_val == $past(p9_q[8]))
		else $error("nine bit payload broken");
	pay_prbs15_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		bit_en && pkt_q && run_pay_q == 8'h03 |=> o_bits.bit_val == $past(p15_q[14]))
		else $error("fifteen bit payload broken");
	pay_ones_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		bit_en && pkt_q && run_pay_q == 8'h04 |=> o_bits.bit_val)
		else $error("all ones payload broken");
	phy_2m_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		go && cmd_ok && phy_q == 8'h02 |=> o_radio.phy == RTTC_PHY_2M)
		else $error("2M phy not selected");
	phy_s2_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		go && cmd_ok && phy_q == 8'h04 |=> o_radio.phy == RTTC_PHY_S2)
		else $error("coded S2 phy not selected");
	pact_pass_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		go && cmd_ok && signed'(pwr_q) <= signed'(MAX_POWER_DBM) |=> pact_q == $past(pwr_q))
		else $error("reachable power not applied");
	bad_pwr_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		go && opc_ok && signed'(pwr_q) > signed'(`RTTC_PWR_MAX)
		|=> !active_q && status_q == `RTTC_ST_BADPARAM)
		else $error("power above range accepted");
	pmax_read_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		i_rd && i_addr == `RTTC_ADDR_PMAX |=> o_rdata == {8'h00, MAX_POWER_DBM})
		else $error("maximum power read wrong");
	status_read_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		i_rd && i_addr == `RTTC_ADDR_STATUS |=> o_rdata == {8'h00, $past(status_q)})
		else $error("status read wrong");
	no_frame_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		!pkt_q |=> !o_bits.byte_last && !o_bits.pkt_last)
		else $error("framing seen in continuous mode");
	bad_pay_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
		go && opc_ok && mode_q == 8'h00 && pay_q > `RTTC_PAY_MAX
		|=> !active_q && status_q == `RTTC_ST_BADPARAM)
		else $error("reserved payload accepted");
endmodule

// [test/rttc_host.sv]
`timescale 1ns/1ps
module rttc_host (
	input wire logic i_clk,
	input wire logic [15:0] i_rdata,
	output logic [3:0] o_addr,
	output logic [15:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	initial begin
		o_addr = 4'h0;
		o_wdata = 16'h0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so they are taken just after that edge.
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		#1;
		d = i_rdata;
	endtask
	// Parameters go one byte each in the low bits, opcode whole, and the GO write comes last.
	task automatic send(input logic [15:0] opc, input logic [7:0] m, c, l, y, p, w);
		wr(4'h0, opc);
		wr(4'h1, {8'h00, m});
		wr(4'h2, {8'h00, c});
		wr(4'h3, {8'h00, l});
		wr(4'h4, {8'h00, y});
		wr(4'h5, {8'h00, p});
		wr(4'h6, {8'h00, w});
		wr(4'h7, 16'h0001);
	endtask
endmodule

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
	import rttc_pkg::*;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] addr;
	logic [15:0] wdata;
	logic wr;
	logic rd;
	logic [15:0] rdata;
	logic [15:0] d;
	logic [7:0] i;
	rttc_radio_t radio;
	rttc_bits_t bits;
	logic [15:0] lastv;
	logic [15:0] pktv;
	int errors = 0;
	int n_compared = 0;
	always #4 ref_clk = ~ref_clk;
	rttc_host u_host (.i_clk(ref_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
		.o_wr(wr), .o_rd(rd));
	// A short bit period keeps the serial pattern checks within a few dozen cycles.
	rttc_top #(.BIT_DIV(4)) u_dut (.i_ref_clk(ref_clk), .i_nrst(nrst), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_radio(radio), .o_bits(bits));
	task print_verdict();
		if (errors == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task run(input logic [15:0] opc, input logic [7:0] m, c, l, y, p, w, s);
		logic [15:0] r;
		u_host.send(opc, m, c, l, y, p, w);
		u_host.rd(4'h8, r);
		chk({8'h00, s}, r);
		chk({15'h0000, s == 8'h00}, {15'h0000, radio.active});
	endtask
	task bitchk(input logic e);
		int k;
		for (k = 0; k < 40 && bits.bit_valid !== 1'b1; k++) begin
			@(posedge ref_clk);
			#1;
		end
		if (k == 40) begin
			errors++;
			print_verdict();
		end else begin
			chk({15'h0000, e}, {15'h0000, bits.bit_val});
			lastv = {lastv[14:0], bits.byte_last};
			pktv = {pktv[14:0], bits.pkt_last};
			// Step past this pulse so that the next call waits for a fresh bit.
			@(posedge ref_clk);
			#1;
		end
	endtask
	task seqchk(input logic [15:0] e, input logic [15:0] el, input logic [15:0] ep);
		int j;
		for (j = 15; j >= 0; j--) begin
			bitchk(e[j]);
		end
		chk(el, lastv);
		chk(ep, pktv);
	endtask
	// First sixteen bits after a start, first bit highest; both sequences start from all ones.
	function automatic logic [15:0] exp_bits(input logic pkt, input logic [7:0] c);
		logic [15:0] r;
		r = 16'h0000;
		if (pkt) begin
			case (c)
				8'h00: r = 16'hff83;
				8'h01: r = 16'hf0f0;
				8'h02: r = 16'haaaa;
				8'h03: r = 16'hfffe;
				8'h04: r = 16'hffff;
				8'h06: r = 16'h0f0f;
				8'h07: r = 16'h5555;
				default: r = 16'h0000;
			endcase
		end else begin
			case (c)
				8'h01: r = 16'hff83;
				8'h02: r = 16'hfffe;
				8'h04: r = 16'hffff;
				8'h05: r = 16'h5555;
				8'h06: r = 16'h3333;
				8'h07: r = 16'h0f0f;
				8'h08: r = 16'h00ff;
				default: r = 16'h0000;
			endcase
		end
		return r;
	endfunction
	initial begin
		#200000;
		errors++;
		print_verdict();
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk(16'h0000, {15'h0000, radio.active});
		u_host.rd(4'h8, d);
		chk(16'h0000, d);
		run(16'hfcca, 8'h00, 8'h27, 8'h01, 8'h00, 8'h01, 8'h14, 8'h00);
		chk(16'h0001, {15'h0000, radio.packet_tx_mode});
		chk(16'h0027, {8'h00, radio.chan});
		chk(16'h000a, {8'h00, radio.power});
		u_host.rd(4'h0, d);
		chk(16'hfcca, d);
		u_host.rd(4'h2, d);
		chk(16'h0027, d);
		u_host.rd(4'h9, d);
		chk(16'h000a, d);
		u_host.rd(4'ha, d);
		chk(16'h000a, d);
		u_host.wr(4'h8, 16'hffff);
		u_host.rd(4'h8, d);
		chk(16'h0000, d);
		u_host.rd(4'hf, d);
		chk(16'h0000, d);
		run(16'hfccb, 8'h08, 8'h00, 8'hff, 8'hff, 8'h04, 8'h81, 8'h00);
		chk(16'h0000, {15'h0000, radio.packet_tx_mode});
		u_host.rd(4'ha, d);
		chk(16'h0081, d);
		for (i = 8'h01; i <= 8'h04; i++) begin
			run(16'hfcca, 8'h01, 8'h00, 8'h00, 8'h00, i, 8'h00, 8'h00);
			chk({8'h00, i - 8'h01}, {14'h0000, radio.phy});
		end
		for (i = 8'h01; i <= 8'h08; i++) begin
			run(16'hfccb, i, 8'h05, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00);
			seqchk(exp_bits(1'b0, i), 16'h0000, 16'h0000);
		end
		for (i = 8'h00; i <= 8'h07; i++) begin
			run(16'hfcca, 8'h00, 8'h10, 8'h02, i, 8'h01, 8'h00, 8'h00);
			seqchk(exp_bits(1'b1, i), 16'h0101, 16'h0001);
		end
		run(16'hfccb, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00);
		bitchk(1'b0);
		run(16'hfccb, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00);
		bitchk(1'b1);
		run(16'hfcc2, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01);
		run(16'hfcca, 8'h09, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h12);
		run(16'hfcca, 8'h00, 8'h28, 8'h01, 8'h00, 8'h01, 8'h00, 8'h12);
		run(16'hfcca, 8'h00, 8'h00, 8'h01, 8'h08, 8'h01, 8'h00, 8'h12);
		run(16'hfcca, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h12);
		run(16'hfcca, 8'h00, 8'h00, 8'h01, 8'h00, 8'h05, 8'h00, 8'h12);
		run(16'hfcca, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h80, 8'h12);
		run(16'hfcca, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h15, 8'h12);
		print_verdict();
	end
endmodule
